/* File: hdcr_top.sv */
// Purpose: Hub device configuration register and the logic it steers
// Assumes: Loader port writes bytes from an EEPROM image or an SMBus host
// Notes:   Reserved bits 4 and 0 are fixed, reserved bit 1 is writable; writes touch only writable fields
//
// How it works
// - bit 7 gates string register writes
// - bit 6 gates serial number writes
// - bit 5 clear allows U1/U2
// - bit 5 set blocks U1/U2 unless forced
// - forced accept holds until reset/disconnect
// - EEPROM load sets config bits
// - SMBus host may overwrite config bits
// - bit 4 always reads one
// - gang bit sampled from strap at release
// - not ganged: per-port power control
// - ganged: port one output drives all
// - power bit sampled from strap at release
// - power bit set disables status reporting
// - bit 0 always reads zero
// - register at offset 5h, reset 0001xx00
// - bad EEPROM signature aborts the load
`timescale 1ns/1ps
module hdcr_top
  import hdcr_pkg::*;
#(
  parameter int NPORT = HDCR_NUM_PORTS
) (
  // Clock and reset
  input  wire logic             I_MCLK,
  input  wire logic             I_RST,
  // Strap pins
  input  wire logic             I_GANG_STRAP_PIN,
  input  wire logic             I_POWER_MGMT_STRAP_PIN,
  // Loader write port
  input  wire logic             I_WR_EN,
  input  wire hdcr_src_t        I_WR_SRC,
  input  wire logic [7:0]       I_WR_ADDR,
  input  wire logic [7:0]       I_WR_DATA,
  input  wire logic             I_EEPROM_START,
  // Read port
  input  wire logic [7:0]       I_RD_ADDR,
  output logic [7:0]            O_RD_DATA,
  // Link power management
  input  wire logic             I_FORCED_LINK_PM_ACCEPT_MSG,
  input  wire logic             I_UPSTREAM_DISCONNECT,
  output logic                  O_LOW_POWER_LINK_ALLOWED,
  // Port power
  input  wire logic [NPORT-1:0] I_PORT_POWER_REQ,
  output logic [NPORT-1:0]      O_PORT_POWER_CONTROL_OUTPUTS,
  output logic                  O_POWER_STATUS_REPORT_EN,
  // Write gates for other registers
  output logic                  O_STRING_WRITE_ENABLE,
  output logic                  O_SERIAL_WRITE_ENABLE
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic       eep_ok_q;
  logic       eep_ok_d;
  logic       force_q;
  logic       force_d;
  logic       strap_load;
  logic       strap_gang;
  logic       strap_pwr;
  logic       wr_cfg;

  hdcr_strap u_strap (
    .i_clk      (I_MCLK),
    .i_rst      (I_RST),
    .i_gang_pin (I_GANG_STRAP_PIN),
    .i_pwr_pin  (I_POWER_MGMT_STRAP_PIN),
    .o_load     (strap_load),
    .o_gang     (strap_gang),
    .o_pwr      (strap_pwr)
  );

  assign wr_cfg = I_WR_EN && (I_WR_ADDR == HDCR_OFS_DEVCFG) &&
                  ((I_WR_SRC == HDCR_SRC_SMBUS) ||
                   (I_WR_SRC == HDCR_SRC_EEPROM && eep_ok_q));

  always_comb begin
    cfg_d    = cfg_q;
    eep_ok_d = eep_ok_q;
    if (I_EEPROM_START) begin
      eep_ok_d = 1'b0;
    end
    // signature check gates the EEPROM load
    if (I_WR_EN && I_WR_SRC == HDCR_SRC_EEPROM && I_WR_ADDR == HDCR_OFS_SIGNATURE) begin
      eep_ok_d = (I_WR_DATA == HDCR_SIGNATURE_VAL);
    end
    // gang and power bits from straps at release
    if (strap_load) begin
      cfg_d[HDCR_BIT_GANG]   = strap_gang;
      cfg_d[HDCR_BIT_PWROFF] = strap_pwr;
    end
    // EEPROM and SMBus writes update fields
    if (wr_cfg) begin
      cfg_d = (cfg_q & ~HDCR_WR_MASK) | (I_WR_DATA & HDCR_WR_MASK);
    end
    cfg_d[HDCR_BIT_RSVD1] = 1'b1;
    cfg_d[HDCR_BIT_RSVD0] = 1'b0;
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_q    <= HDCR_RST_DEVCFG;
      eep_ok_q <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      eep_ok_q <= eep_ok_d;
    end
  end

  // forced accept latched until disconnect or reset
  always_comb begin
    force_d = force_q;
    if (I_UPSTREAM_DISCONNECT) begin
      force_d = 1'b0;
    end
    if (I_FORCED_LINK_PM_ACCEPT_MSG) begin
      force_d = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      force_q <= 1'b0;
    end else begin
      force_q <= force_d;
    end
  end

  assign O_LOW_POWER_LINK_ALLOWED = !cfg_q[HDCR_BIT_LPDIS] || force_q;

  assign O_STRING_WRITE_ENABLE = cfg_q[HDCR_BIT_STRING];
  assign O_SERIAL_WRITE_ENABLE = cfg_q[HDCR_BIT_SERIAL];
  // status reporting when power bit clear
  assign O_POWER_STATUS_REPORT_EN = !cfg_q[HDCR_BIT_PWROFF];

  logic [NPORT-1:0] pwr_d;
  logic [NPORT-1:0] pwr_q;
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      if (gi == 0) begin : g_first
        assign pwr_d[gi] = cfg_q[HDCR_BIT_GANG] ? |I_PORT_POWER_REQ : I_PORT_POWER_REQ[gi];
      end else begin : g_rest
        assign pwr_d[gi] = cfg_q[HDCR_BIT_GANG] ? 1'b0 : I_PORT_POWER_REQ[gi];
      end
    end
  endgenerate

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pwr_q <= '0;
    end else begin
      pwr_q <= pwr_d;
    end
  end
  assign O_PORT_POWER_CONTROL_OUTPUTS = pwr_q;

  assign O_RD_DATA = (I_RD_ADDR == HDCR_OFS_DEVCFG) ? cfg_q : 8'h00;

  // Assertions
  chk_rsvd_one: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_RD_DATA[HDCR_BIT_RSVD1] == (I_RD_ADDR == HDCR_OFS_DEVCFG))
    else $error("reserved bit 4 not one");
  chk_rsvd_zero: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !cfg_q[HDCR_BIT_RSVD0]) else $error("reserved bit 0 not zero");
  chk_lp_block: assert property (@(posedge I_MCLK) disable iff (I_RST)
    cfg_q[HDCR_BIT_LPDIS] && !force_q |-> !O_LOW_POWER_LINK_ALLOWED)
    else $error("low power allowed while disabled");
  chk_lp_normal: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !cfg_q[HDCR_BIT_LPDIS] |-> O_LOW_POWER_LINK_ALLOWED)
    else $error("low power blocked while enabled");
  chk_force_hold: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_FORCED_LINK_PM_ACCEPT_MSG |=> force_q)
    else $error("forced accept lost");
  chk_smbus_write: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_WR_EN && I_WR_SRC == HDCR_SRC_SMBUS && I_WR_ADDR == HDCR_OFS_DEVCFG |=>
    cfg_q[7:5] == $past(I_WR_DATA[7:5]))
    else $error("SMBus write not taken");
  chk_sig_abort: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !eep_ok_q && I_WR_SRC == HDCR_SRC_EEPROM && I_WR_ADDR == HDCR_OFS_DEVCFG &&
    !strap_load |=> $stable(cfg_q))
    else $error("EEPROM load without signature");
  chk_gang_out: assert property (@(posedge I_MCLK) disable iff (I_RST)
    cfg_q[HDCR_BIT_GANG] |=> pwr_q[NPORT-1:1] == '0)
    else $error("ganged mode drives other ports");
  chk_report: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_POWER_STATUS_REPORT_EN != cfg_q[HDCR_BIT_PWROFF])
    else $error("status report mismatch");
  chk_port_each: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !cfg_q[HDCR_BIT_GANG] |=> pwr_q == $past(I_PORT_POWER_REQ))
    else $error("per-port power not followed");
  chk_strap_take: assert property (@(posedge I_MCLK) disable iff (I_RST)
    strap_load && !wr_cfg |=> cfg_q[HDCR_BIT_GANG] == $past(strap_gang) &&
    cfg_q[HDCR_BIT_PWROFF] == $past(strap_pwr))
    else $error("strap not captured");
endmodule : hdcr_top

/* File: hdcr_pkg.sv */
// Purpose: Constants for the hub device configuration register bank
// Assumes: 8-bit register file reached by the configuration loader port
// Notes:   Offsets, field positions and reset values live here
package hdcr_pkg;
  localparam logic [7:0] HDCR_OFS_SIGNATURE = 8'h00;
  localparam logic [7:0] HDCR_OFS_DEVCFG    = 8'h05;
  localparam logic [7:0] HDCR_SIGNATURE_VAL = 8'h55;
  localparam int HDCR_BIT_STRING  = 7;
  localparam int HDCR_BIT_SERIAL  = 6;
  localparam int HDCR_BIT_LPDIS   = 5;
  localparam int HDCR_BIT_RSVD1   = 4;
  localparam int HDCR_BIT_GANG    = 3;
  localparam int HDCR_BIT_PWROFF  = 2;
  localparam int HDCR_BIT_RSVDRW  = 1;
  localparam int HDCR_BIT_RSVD0   = 0;
  localparam logic [7:0] HDCR_RST_DEVCFG = 8'h10;
  localparam logic [7:0] HDCR_WR_MASK    = 8'hEE;
  localparam int HDCR_NUM_PORTS = 4;
  typedef enum logic [1:0] {
    HDCR_SRC_NONE,
    HDCR_SRC_EEPROM,
    HDCR_SRC_SMBUS
  } hdcr_src_t;
endpackage : hdcr_pkg

/* File: hdcr_strap.sv */
// Purpose: Capture strap pins when reset is released
// Assumes: Strap pins are asynchronous; two flops before use
// Notes:   Pulses o_load once, in the cycle after the second edge after release
`timescale 1ns/1ps
module hdcr_strap (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Strap pins
  input  wire logic i_gang_pin,
  input  wire logic i_pwr_pin,
  // Captured values
  output logic      o_load,
  output logic      o_gang,
  output logic      o_pwr
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic       done_q;
  logic       done_d;

  always_comb begin
    done_d = 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      done_q <= 1'b0;
    end else begin
      meta_q <= {i_gang_pin, i_pwr_pin};
      sync_q <= meta_q;
      done_q <= done_d;
    end
  end

  // Load on the cycle the synchronised value is first valid
  logic [1:0] cnt_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 2'h0;
    end else if (cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign o_load = (cnt_q == 2'h2) && done_q;
  assign o_gang = sync_q[1];
  assign o_pwr  = sync_q[0];
endmodule : hdcr_strap

/* File: hdcr_loader_model.sv */
// Purpose: Loader model, EEPROM image or SMBus host byte writes
// Assumes: One request pulse per byte from the bench
// Notes:   Idle address and data lines show the inverse of the last value
`timescale 1ns/1ps
module hdcr_loader_model
  import hdcr_pkg::*;
(
  // Bench request
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire hdcr_src_t  i_src,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_data,
  // Write port toward the register
  output logic            o_wr_en = 1'b0,
  output hdcr_src_t       o_src   = HDCR_SRC_NONE,
  output logic [7:0]      o_addr  = 8'h00,
  output logic [7:0]      o_data  = 8'h00
);
  always @(posedge i_clk) begin
    o_wr_en <= i_go;
    o_src   <= i_go ? i_src : HDCR_SRC_NONE;
    o_addr  <= i_go ? i_addr : ~o_addr;
    o_data  <= i_go ? (i_data & 8'hFD) : ~o_data;
  end
endmodule : hdcr_loader_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the device configuration register
// Assumes: Loader model drives the write port one byte at a time
// Notes:   Straps start at gang one, power management zero; reboot flips them
`timescale 1ns/1ps
module testbench;
  import hdcr_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       go = 1'b0;
  hdcr_src_t  src = HDCR_SRC_NONE;
  logic [7:0] addr = 8'h00;
  logic [7:0] data = 8'h00;
  logic       start = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic       msg = 1'b0;
  logic       disc = 1'b0;
  logic [3:0] req = 4'h0;
  logic       gang_pin = 1'b1;
  logic       pwr_pin = 1'b0;
  logic       wr_en, lp_ok, rep_en, str_en, ser_en;
  hdcr_src_t  wr_src;
  logic [7:0] wr_addr, wr_data, rd_data;
  logic [3:0] pwr_out;
  int         err_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;

  hdcr_loader_model u_host (.i_clk(clk), .i_go(go), .i_src(src), .i_addr(addr),
    .i_data(data), .o_wr_en(wr_en), .o_src(wr_src), .o_addr(wr_addr), .o_data(wr_data));
  hdcr_top u_dut (.I_MCLK(clk), .I_RST(rst), .I_GANG_STRAP_PIN(gang_pin),
    .I_POWER_MGMT_STRAP_PIN(pwr_pin), .I_WR_EN(wr_en), .I_WR_SRC(wr_src),
    .I_WR_ADDR(wr_addr), .I_WR_DATA(wr_data), .I_EEPROM_START(start),
    .I_RD_ADDR(rd_addr), .O_RD_DATA(rd_data), .I_FORCED_LINK_PM_ACCEPT_MSG(msg),
    .I_UPSTREAM_DISCONNECT(disc), .O_LOW_POWER_LINK_ALLOWED(lp_ok),
    .I_PORT_POWER_REQ(req), .O_PORT_POWER_CONTROL_OUTPUTS(pwr_out),
    .O_POWER_STATUS_REPORT_EN(rep_en), .O_STRING_WRITE_ENABLE(str_en),
    .O_SERIAL_WRITE_ENABLE(ser_en));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input hdcr_src_t s, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    go <= 1'b1;
    src <= s;
    addr <= a;
    data <= d;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_addr <= a;
    #1;
    check("read data", rd_data, exp);
  endtask : rd

  task automatic t_reset();
    rd(HDCR_OFS_DEVCFG, 8'h18);
    rd(8'h01, 8'h00);
    check("link allowed", lp_ok, 1'b1);
    check("report enable", rep_en, 1'b1);
    check("string enable", str_en, 1'b0);
  endtask : t_reset

  task automatic t_smbus();
    wr(HDCR_SRC_SMBUS, HDCR_OFS_DEVCFG, 8'hFF);
    rd(HDCR_OFS_DEVCFG, 8'hFC);
    check("string enable", str_en, 1'b1);
    check("serial enable", ser_en, 1'b1);
    check("link allowed", lp_ok, 1'b0);
    check("report enable", rep_en, 1'b0);
  endtask : t_smbus

  task automatic t_forced();
    @(posedge clk);
    msg <= 1'b1;
    @(posedge clk);
    msg <= 1'b0;
    wr(HDCR_SRC_SMBUS, HDCR_OFS_DEVCFG, 8'hFC);
    check("forced allowed", lp_ok, 1'b1);
    @(posedge clk);
    disc <= 1'b1;
    @(posedge clk);
    disc <= 1'b0;
    @(posedge clk);
    #1;
    check("after disconnect", lp_ok, 1'b0);
    wr(HDCR_SRC_SMBUS, HDCR_OFS_DEVCFG, 8'h00);
    check("link allowed", lp_ok, 1'b1);
    check("serial enable", ser_en, 1'b0);
  endtask : t_forced

  task automatic t_power();
    @(posedge clk);
    req <= 4'hA;
    repeat (2) @(posedge clk);
    #1;
    check("per port power", pwr_out, 4'hA);
    wr(HDCR_SRC_SMBUS, HDCR_OFS_DEVCFG, 8'h08);
    check("ganged power", pwr_out, 4'h1);
  endtask : t_power

  task automatic t_eeprom();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wr(HDCR_SRC_EEPROM, HDCR_OFS_DEVCFG, 8'h20);
    rd(HDCR_OFS_DEVCFG, 8'h18);
    wr(HDCR_SRC_EEPROM, HDCR_OFS_SIGNATURE, 8'h54);
    wr(HDCR_SRC_EEPROM, HDCR_OFS_DEVCFG, 8'h20);
    rd(HDCR_OFS_DEVCFG, 8'h18);
    wr(HDCR_SRC_EEPROM, HDCR_OFS_SIGNATURE, HDCR_SIGNATURE_VAL);
    wr(HDCR_SRC_EEPROM, HDCR_OFS_DEVCFG, 8'h20);
    rd(HDCR_OFS_DEVCFG, 8'h30);
  endtask : t_eeprom

  // Mid-run reset with flipped straps; reset must also drop the forced flag
  task automatic t_reboot();
    @(posedge clk);
    msg <= 1'b1;
    @(posedge clk);
    msg <= 1'b0;
    rst <= 1'b1;
    gang_pin <= 1'b0;
    pwr_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rd(HDCR_OFS_DEVCFG, 8'h14);
    check("report enable", rep_en, 1'b0);
    check("per port power", pwr_out, 4'hA);
    wr(HDCR_SRC_SMBUS, HDCR_OFS_DEVCFG, 8'h24);
    check("reset clears force", lp_ok, 1'b0);
  endtask : t_reboot

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_smbus();
    t_forced();
    t_power();
    t_eeprom();
    t_reboot();
    give_verdict();
  end
endmodule : testbench
